// ### bench/sfm_core_chk.sv
// Purpose: port level checks of the serial memory engine
// Assumes: pins synchronised by two flops, output from register
// Notes:   bound from the testbench top file
module sfm_core_chk (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic hold_n,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic write_permit_flag,
   input wire logic wr_queue_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   chk_reset_quiet: assert property ($fell(sys_rst) |->
      !miso_oe && !write_permit_flag) else $error("busy after reset");
   chk_queue_ready: assert property (!$past(sys_rst) |-> wr_queue_ready)
      else $error("queue not ready");
   chk_deselect_off: assert property (cs_n[*5] |-> !miso_oe)
      else $error("output driven while deselected");
   chk_hold_off: assert property (!hold_n[*5] |-> !miso_oe)
      else $error("output driven during hold");
   chk_oe_on_fall: assert property ($rose(miso_oe) |->
      !cs_n && !$past(sck, 2)) else $error("output enabled off a fall");
   chk_shift_on_fall: assert property (miso_oe && $past(miso_oe) &&
      $changed(miso_o) |-> !$past(sck, 2)) else $error("bit moved on rise");
   chk_flag_set_rise: assert property ($rose(write_permit_flag) |->
      !cs_n && $past(sck, 3)) else $error("flag set off a clock rise");
   chk_flag_clr_desel: assert property ($fell(write_permit_flag) |->
      cs_n && $past(cs_n, 2)) else $error("flag cleared while selected");
   cover property ($rose(miso_oe));
   cover property ($fell(write_permit_flag));
   cover property (!hold_n[*5]);
   cover property (!hold_n && $past(miso_oe));
endmodule

// ### bench/sfm_master.sv
// Purpose: spi bus master model, mode 0
// Assumes: serial clock period 125 ns, still outside frames
// Notes:   data line inverted once released
module sfm_master (
   output logic            sck,
   output logic            cs_n,
   output logic            mosi,
   output logic            hold_n,
   input  wire logic       miso_o,
   input  wire logic       miso_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] rx;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      hold_n = 1'b1;
   end
   task automatic sel();
      cs_n <= 1'b0;
      #62.5;
   endtask
   // released data line shows the inverse of its last bit
   task automatic desel();
      #62.5 cs_n <= 1'b1;
      mosi <= ~mosi;
      #300;
   endtask
   // fewer than 8 bits leaves a partial byte
   task automatic xfer(input logic [7:0] tx, input int nbits = 8,
                       input int hold_at = 9);
      for (int i = 0; i < nbits; i++) begin
         if (i == hold_at) begin
            hold_n <= 1'b0;
            repeat (3) begin
               #62.5 sck <= 1'b1;
               #62.5 sck <= 1'b0;
            end
            hold_n <= 1'b1;
         end
         mosi <= tx[7-i];
         #62.5 sck <= 1'b1;
         rx[7-i] = miso_oe ? miso_o : 1'bz;
         #62.5 sck <= 1'b0;
      end
   endtask
endmodule

// ### bench/tb.sv
// Purpose: self-checking bench of the serial memory engine
// Assumes: 100 MHz clock, master model on the pins
// Notes:   array checked by reading back
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import sfm_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic block_protect_hi = 1'b0;
   logic block_protect_lo = 1'b0;
   logic sck, cs_n, mosi, hold_n, miso_o, miso_oe;
   logic write_permit_flag, wr_queue_ready;
   int   num_errors = 0;
   int   checked = 0;
   always #5 clock = ~clock;
   sfm_core dut (.clock, .sys_rst, .sck, .cs_n, .mosi, .hold_n,
      .block_protect_hi, .block_protect_lo, .miso_o, .miso_oe,
      .write_permit_flag, .wr_queue_ready);
   sfm_master m (.sck, .cs_n, .mosi, .hold_n, .miso_o, .miso_oe);
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(logic [7:0] op, logic [15:0] a);
      m.sel();
      m.xfer(op);
      m.xfer(a[15:8]);
      m.xfer(a[7:0]);
   endtask
   task automatic enable();
      m.sel();
      m.xfer(OP_SET_LATCH);
      m.desel();
      check("flag set", 8'h01, {7'h0, write_permit_flag});
   endtask
   task automatic rd(logic [15:0] a, logic [7:0] exp[$]);
      cmd(OP_READ, a);
      foreach (exp[i]) begin
         m.xfer(8'ha5, 8, (i == 1) ? 5 : 9);
         check("read byte", exp[i], m.rx);
      end
      m.desel();
      check("output off", 8'h00, {7'h0, miso_oe});
   endtask
   task automatic wr(logic [15:0] a, logic [7:0] d[$]);
      enable();
      cmd(OP_WRITE, a);
      foreach (d[i]) m.xfer(d[i], 8, (i == 1) ? 3 : 9);
      m.desel();
      check("flag clear", 8'h00, {7'h0, write_permit_flag});
   endtask
   task automatic t_reset();
      check("reset oe", 8'h00, {7'h0, miso_oe});
      check("ready", 8'h01, {7'h0, wr_queue_ready});
   endtask
   task automatic t_burst();
      wr(16'hfffe, '{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5});
      enable();
      cmd(OP_WRITE, 16'h0003);
      m.xfer(8'h3c, 4);
      m.desel();
      cmd(OP_WRITE, 16'h0002);
      m.xfer(8'h99);
      m.desel();
      rd(16'h1ffe, '{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5});
   endtask
   task automatic t_protect();
      for (int b = 3; b >= 0; b--) begin
         @(posedge clock);
         {block_protect_hi, block_protect_lo} <= b[1:0];
         wr(16'h1fff, '{8'h40 | b[7:0], 8'h50});
         if (b == 0)
            rd(16'h1fff, '{8'h40, 8'h50});
         else
            rd(16'h1fff, '{8'hc1, 8'hc2});
      end
   endtask
   task automatic t_unknown();
      m.sel();
      m.xfer(8'h81);
      m.xfer(OP_READ);
      repeat (3) m.xfer(8'h00);
      check("no drive", 8'hzz, m.rx);
      m.desel();
   endtask
   task automatic report_and_stop();
      $display("checked %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clock);
      t_reset();
      t_burst();
      t_protect();
      t_unknown();
      report_and_stop();
   end
   initial begin
      repeat (90000) @(posedge clock);
      num_errors++;
      report_and_stop();
   end
endmodule
bind sfm_core sfm_core_chk chk (.clock, .sys_rst, .sck, .cs_n, .hold_n,
   .miso_o, .miso_oe, .write_permit_flag, .wr_queue_ready);

// ### rtl/sfm_core.sv
// Overview of operation
// RULE_01 - master sends enable command before writing
// RULE_02 - two address bytes, low 13 bits used
// RULE_03 - top three address bits of write ignored
// RULE_04 - store byte, then advance address
// RULE_05 - address wraps from 1FFFh to 0000h
// RULE_06 - data shifted most significant bit first
// RULE_07 - chip select rise ends write
// RULE_08 - protected address stops increment, drops bytes
// RULE_09 - byte committed right after eighth clock
// RULE_10 - partial bytes never reach the array
// RULE_11 - write bursts have no length limit
// RULE_12 - read: opcode, two address bytes, 13 bits
// RULE_13 - read data follows last address bit
// RULE_14 - serial input ignored during read data
// RULE_15 - chip select rise tristates serial output
// RULE_16 - hold low with clock low freezes
// RULE_17 - hold high with clock low resumes
// RULE_18 - hold changes only while clock low
// RULE_19 - opcodes: read 03h, write 02h, enable 06h
// RULE_20 - write end clears write permit flag
// RULE_21 - two bits pick the protected region
// RULE_22 - sample on rise, shift out on fall
// RULE_23 - unknown opcode ignored until deselect
//
// Purpose: serial memory access engine with its own byte array
// Assumes: serial clock sampled by clock, at most a fifth of its rate
// Notes:   protect bits are plain inputs; writes queue through a fifo
module sfm_core
   import sfm_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic       mosi,
   input  wire logic       hold_n,
   input  wire logic       block_protect_hi,
   input  wire logic       block_protect_lo,
   output logic            miso_o,
   output logic            miso_oe,
   output logic            write_permit_flag,
   output logic            wr_queue_ready
);
   import sfm_pkg::*;

   typedef struct packed {
      sfm_pins_t         s1;
      sfm_pins_t         s2;
      logic              sck_d;
      logic              held;
      sfm_state_t        st;
      logic [2:0]        bitc;
      logic              addr_hi;
      logic [7:0]        shin;
      logic [7:0]        shout;
      logic [ADDR_W-1:0] addr;
      logic              stopped;
      logic              wpf;
      logic              is_write;
      logic              so;
      logic              so_en;
      logic              qrdy;
   } sfm_core_t;

   sfm_core_t         r_reg;
   sfm_core_t         r_next;
   logic [7:0]        mem [1 << ADDR_W];
   logic [7:0]        rd_byte;
   sfm_wr_t           push_data;
   logic              push_valid;
   logic              push_ready;
   sfm_wr_t           pop_data;
   logic              pop_valid;

   function automatic logic is_protected(input logic [ADDR_W-1:0] a,
                                         input logic [1:0] bp);
      unique case (bp) // RULE_21
         BP_NONE:    is_protected = 1'b0;
         BP_QUARTER: is_protected = a >= PROT_QUARTER;
         BP_HALF:    is_protected = a >= PROT_HALF;
         default:    is_protected = 1'b1;
      endcase
   endfunction

   function automatic logic [ADDR_W-1:0] next_addr(
      input logic [ADDR_W-1:0] a);
      next_addr = a + 1'b1; // RULE_05
   endfunction

   sfm_fifo #(
      .WIDTH ($bits(sfm_wr_t)),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_data),
      .out_valid (pop_valid),
      .out_ready (1'b1),
      .out_data  (pop_data)
   );

   // array port drains the queue one byte per clock
   always_ff @(posedge clock) begin
      if (pop_valid) begin
         mem[pop_data.addr] <= pop_data.data; // RULE_09
      end
   end
   assign rd_byte = mem[r_reg.addr];

   always_comb begin
      logic rise;
      logic fall;
      logic [7:0] byte_in;
      logic [ADDR_W-1:0] a;
      rise       = 1'b0;
      fall       = 1'b0;
      byte_in    = '0;
      a          = '0;
      r_next     = r_reg;
      push_valid = 1'b0;
      push_data  = '0;
      r_next.s1  = '{sck: sck, cs_n: cs_n, mosi: mosi, hold_n: hold_n};
      r_next.s2  = r_reg.s1;
      r_next.qrdy = push_ready;
      r_next.sck_d = r_reg.s2.sck;
      // hold edges are taken only while the clock is low
      if (!r_reg.s2.sck) begin
         r_next.held = !r_reg.s2.hold_n; // RULE_16 RULE_17 RULE_18
      end
      rise = r_reg.s2.sck && !r_reg.sck_d && !r_next.held;
      // a fall seen with the hold still counts, one seen while held does not
      fall = !r_reg.s2.sck && r_reg.sck_d && !r_reg.held;
      r_next.so_en = r_reg.so_en && !r_next.held;
      if (r_reg.held && !r_next.held && r_reg.st == ST_RDATA) begin
         r_next.so_en = 1'b1;
      end
      if (r_reg.s2.cs_n) begin
         // deselect ends any transfer
         if (r_reg.st != ST_IDLE && r_reg.is_write) begin
            r_next.wpf = 1'b0; // RULE_20
         end
         r_next.st       = ST_IDLE; // RULE_07 RULE_23
         r_next.so_en    = 1'b0; // RULE_15
         r_next.bitc     = '0;
         r_next.is_write = 1'b0;
         r_next.stopped  = 1'b0;
         r_next.held     = 1'b0;
      end else begin
         if (r_reg.st == ST_IDLE) begin
            r_next.st   = ST_OPCODE;
            r_next.bitc = '0;
         end
         if (rise && r_reg.st != ST_RDATA) begin
            byte_in     = {r_reg.shin[6:0], r_reg.s2.mosi}; // RULE_06 RULE_22
            r_next.shin = byte_in;
            r_next.bitc = r_reg.bitc + 1'b1;
         end
         if (rise && r_reg.st == ST_RDATA) begin
            r_next.bitc = r_reg.bitc + 1'b1; // RULE_14
         end
         if (rise && r_reg.bitc == BIT_LAST) begin
            unique case (r_reg.st)
               ST_OPCODE: begin
                  if (byte_in == OP_READ || byte_in == OP_WRITE) begin
                     r_next.st       = ST_ADDR; // RULE_19
                     r_next.is_write = byte_in == OP_WRITE;
                     r_next.addr_hi  = 1'b1;
                  end else if (byte_in == OP_SET_LATCH) begin
                     r_next.wpf = 1'b1; // RULE_01
                     r_next.st  = ST_IGNORE;
                  end else begin
                     r_next.st = ST_IGNORE; // RULE_23
                  end
               end
               ST_ADDR: begin
                  if (r_reg.addr_hi) begin
                     // upper three bits dropped
                     r_next.addr[ADDR_W-1:8] = byte_in[4:0]; // RULE_02 RULE_03
                     r_next.addr_hi = 1'b0;
                  end else begin
                     r_next.addr[7:0] = byte_in; // RULE_12
                     r_next.st = r_reg.is_write ? ST_WDATA : ST_RDATA;
                  end
               end
               ST_WDATA: begin
                  // whole bytes only reach the queue
                  a = r_reg.addr;
                  if (!r_reg.wpf || r_reg.stopped ||
                      is_protected(a, {block_protect_hi,
                                       block_protect_lo})) begin
                     r_next.stopped = r_reg.wpf; // RULE_08
                  end else begin
                     push_valid     = 1'b1; // RULE_09 RULE_10
                     push_data      = '{addr: a, data: byte_in};
                     r_next.addr    = next_addr(a); // RULE_04 RULE_11
                  end
               end
               ST_RDATA: begin
                  r_next.addr = next_addr(r_reg.addr); // RULE_05 RULE_13
               end
               default: begin
                  r_next.st = r_reg.st;
               end
            endcase
         end
         // output shifts on falling edges during read data
         if (fall && r_reg.st == ST_RDATA) begin
            if (r_reg.bitc == '0) begin
               r_next.shout = rd_byte; // RULE_13
            end else begin
               r_next.shout = {r_reg.shout[6:0], 1'b0};
            end
            r_next.so    = r_next.shout[7]; // RULE_06 RULE_22
            r_next.so_en = !r_next.held; // RULE_16
         end
      end
      if (sys_rst) begin
         r_next      = '0;
         r_next.st   = ST_IDLE;
         r_next.s1   = '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0, hold_n: 1'b1};
         r_next.s2   = '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0, hold_n: 1'b1};
      end
   end

   always_ff @(posedge clock) begin
      r_reg <= r_next;
   end

   assign miso_o            = r_reg.so;
   assign miso_oe           = r_reg.so_en;
   assign write_permit_flag = r_reg.wpf;
   assign wr_queue_ready    = r_reg.qrdy;
endmodule

// ### rtl/sfm_fifo.sv
// Purpose: write queue between the serial engine and the array port
// Assumes: one clock, synchronous reset
// Notes:   valid and ready on both sides
module sfm_fifo #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 32
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_ready  = count_reg != (AW+1)'(DEPTH);
   assign out_valid = count_reg != '0;
   assign out_data  = mem[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

// ### shared/sfm_pkg.sv
// Purpose: shared constants and types for the serial memory access block
// Assumes: system clock far faster than the serial clock
// Notes:   one-hot state codes, opcode values, protect ranges
package sfm_pkg;
   localparam int          ADDR_W        = 13;
   localparam int          DATA_W        = 8;
   localparam int          FIFO_DEPTH    = 32;
   localparam logic [7:0]  OP_READ       = 8'h03;
   localparam logic [7:0]  OP_WRITE      = 8'h02;
   localparam logic [7:0]  OP_SET_LATCH  = 8'h06;
   localparam logic [2:0]  BIT_LAST      = 3'h7;
   localparam logic [ADDR_W-1:0] ADDR_ZERO    = 13'h0000;
   localparam logic [ADDR_W-1:0] PROT_QUARTER = 13'h1800;
   localparam logic [ADDR_W-1:0] PROT_HALF    = 13'h1000;
   localparam logic [1:0]  BP_NONE       = 2'h0;
   localparam logic [1:0]  BP_QUARTER    = 2'h1;
   localparam logic [1:0]  BP_HALF       = 2'h2;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_OPCODE = 6'h02,
      ST_ADDR   = 6'h04,
      ST_WDATA  = 6'h08,
      ST_RDATA  = 6'h10,
      ST_IGNORE = 6'h20
   } sfm_state_t;

   // one byte headed for the array
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } sfm_wr_t;

   // synchronised pin levels
   typedef struct packed {
      logic sck;
      logic cs_n;
      logic mosi;
      logic hold_n;
   } sfm_pins_t;
endpackage
